// ### design/switch_controller.sv
`timescale 1ns/1ps
// Functional notes
// - shift data in on rising clock while selected
// - bit n closes switch n when one
// - output is last stage, moves on falling edge
// - output equals input eight clocks later
// - switch 7 bit first in, first out
// - switches hold while bits shift
// - select rising latches word, freezes shifting
// - deselected: ignore clock and data, hold output
// - latch on select rise only with clock low
// - master idles clock low
// - power-up clears register, opens switches
// - supply reset pulse clears and opens all
// - shared select updates chained devices together
// - addressed use: one select low, output unused
// - master raises select after the programmed bit count (1 to 32, eight at reset)
module switch_controller (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [switch_link_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// serial link
	switch_link_if.controller link
);
	// ----------------------------------------
	// state and registers
	// ----------------------------------------
	switch_link_pkg::ctl_state_type state_q;
	logic ack_q;
	logic wr_fire;
	logic [31:0] tx_q;
	logic [switch_link_pkg::COUNT_W-1:0] count_q;
	logic [switch_link_pkg::COUNT_W-1:0] left_q;
	logic [switch_link_pkg::TIMER_W-1:0] timer_q;
	logic [31:0] shift_q;
	logic [31:0] rx_q;
	logic done_q;
	logic sclk_q;
	logic cs_n_q;
	logic out_s;
	logic start;
	logic tick;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// every access answered at its second edge
	assign waitrequest = (read | write) & ~ack_q;
	assign wr_fire = write & ack_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read | write) & ~ack_q;
		end
	end

	// read data captured the edge before the answer
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			readdata <= '0;
		end else if (read & ~ack_q) begin
			case (address)
				switch_link_pkg::TX_DATA_OFS: readdata <= tx_q;
				switch_link_pkg::BIT_COUNT_OFS: readdata <= {26'h0, count_q};
				switch_link_pkg::STATUS_OFS: readdata <= {30'h0, done_q, state_q != switch_link_pkg::ST_IDLE};
				switch_link_pkg::RX_DATA_OFS: readdata <= rx_q;
				default: readdata <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tx_q <= '0;
			count_q <= switch_link_pkg::COUNT_RESET; // one word per frame
		end else if (wr_fire) begin
			if (address == switch_link_pkg::TX_DATA_OFS) begin
				tx_q <= writedata;
			end
			if (address == switch_link_pkg::BIT_COUNT_OFS) begin
				count_q <= writedata[switch_link_pkg::COUNT_W-1:0];
			end
		end
	end

	// start only when idle with a usable count
	assign start = wr_fire && address == switch_link_pkg::CTRL_OFS
		&& writedata[switch_link_pkg::CTRL_START_BIT]
		&& state_q == switch_link_pkg::ST_IDLE
		&& count_q != '0 && count_q <= switch_link_pkg::COUNT_MAX;

	// sticky done, set wins over write-one-clear
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			done_q <= 1'b0;
		end else if (state_q == switch_link_pkg::ST_LAG && tick) begin
			done_q <= 1'b1;
		end else if (wr_fire && address == switch_link_pkg::STATUS_OFS
			&& writedata[switch_link_pkg::STATUS_DONE_BIT]) begin
			done_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// return data crossing
	// ----------------------------------------
	sync_two_flop u_out_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.async_in(link.serial_out),
		.sync_out(out_s)
	);

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	// timer counts down and rests at zero
	assign tick = timer_q == '0;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= switch_link_pkg::ST_IDLE;
			timer_q <= '0;
			left_q <= '0;
			shift_q <= '0;
			rx_q <= '0;
			sclk_q <= 1'b0; // idles low
			cs_n_q <= 1'b1;
		end else begin
			if (!tick) begin
				timer_q <= timer_q - 1'b1;
			end
			case (state_q)
				switch_link_pkg::ST_IDLE: begin
					if (start) begin
						// left-justify, top bit of frame first
						shift_q <= tx_q << (switch_link_pkg::COUNT_MAX - count_q);
						left_q <= count_q;
						rx_q <= '0;
						cs_n_q <= 1'b0; // all chained devices
						timer_q <= switch_link_pkg::LEAD_LOAD;
						state_q <= switch_link_pkg::ST_LEAD;
					end
				end
				switch_link_pkg::ST_LEAD, switch_link_pkg::ST_LOW: begin
					if (tick) begin
						sclk_q <= 1'b1;
						rx_q <= {rx_q[30:0], out_s};
						timer_q <= switch_link_pkg::HIGH_LOAD;
						state_q <= switch_link_pkg::ST_HIGH;
					end
				end
				switch_link_pkg::ST_HIGH: begin
					if (tick) begin
						sclk_q <= 1'b0;
						left_q <= left_q - 1'b1;
						// last bit done: clock stays low through the lag
						if (left_q == 6'h01) begin
							timer_q <= switch_link_pkg::LAG_LOAD;
							state_q <= switch_link_pkg::ST_LAG;
						end else begin
							shift_q <= {shift_q[30:0], 1'b0};
							timer_q <= switch_link_pkg::LOW_LOAD;
							state_q <= switch_link_pkg::ST_LOW;
						end
					end
				end
				switch_link_pkg::ST_LAG: begin
					if (tick) begin
						// clock is low here, all chained latches load
						cs_n_q <= 1'b1;
						timer_q <= switch_link_pkg::IDLE_LOAD;
						state_q <= switch_link_pkg::ST_GAP;
					end
				end
				switch_link_pkg::ST_GAP: begin
					// select held high for the idle gap
					if (tick) begin
						state_q <= switch_link_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= switch_link_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// link outputs
	// ----------------------------------------
	// all three wires straight from flops
	assign link.sclk = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.serial_in = shift_q[31];
endmodule // switch_controller

// ### design/switch_link_pkg.sv
package switch_link_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int REF_CLK_NS = 40;
	localparam int SCLK_HIGH_NS = 240;
	localparam int SCLK_LOW_NS = 240;
	localparam int CS_LEAD_NS = 240;
	localparam int CS_LAG_NS = 240;
	localparam int CS_IDLE_NS = 240;

	// least time to whole cycles, at least one
	function automatic int min_cycles(input int ns);
		int c;
		c = (ns + REF_CLK_NS - 1) / REF_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SCLK_HIGH_CYC = min_cycles(SCLK_HIGH_NS);
	localparam int SCLK_LOW_CYC = min_cycles(SCLK_LOW_NS);
	localparam int CS_LEAD_CYC = min_cycles(CS_LEAD_NS);
	localparam int CS_LAG_CYC = min_cycles(CS_LAG_NS);
	localparam int CS_IDLE_CYC = min_cycles(CS_IDLE_NS);
	localparam int TIMER_W = 4;
	localparam logic [TIMER_W-1:0] HIGH_LOAD = TIMER_W'(SCLK_HIGH_CYC - 1);
	localparam logic [TIMER_W-1:0] LOW_LOAD = TIMER_W'(SCLK_LOW_CYC - 1);
	localparam logic [TIMER_W-1:0] LEAD_LOAD = TIMER_W'(CS_LEAD_CYC - 1);
	localparam logic [TIMER_W-1:0] LAG_LOAD = TIMER_W'(CS_LAG_CYC - 1);
	localparam logic [TIMER_W-1:0] IDLE_LOAD = TIMER_W'(CS_IDLE_CYC - 1);

	// ----------------------------------------
	// word layout
	// ----------------------------------------
	localparam int WORD_BITS = 8;
	localparam int FRAME_BITS = 32;
	localparam int COUNT_W = 6;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 6'h20;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 6'h08;

	// ----------------------------------------
	// controller registers
	// ----------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
	localparam logic [ADDR_W-1:0] TX_DATA_OFS = 5'h04;
	localparam logic [ADDR_W-1:0] BIT_COUNT_OFS = 5'h08;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h0c;
	localparam logic [ADDR_W-1:0] RX_DATA_OFS = 5'h10;
	localparam int CTRL_START_BIT = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;

	typedef enum {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_LAG, ST_GAP} ctl_state_type;
endpackage

// ### design/switch_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// three-wire link with return data
// ----------------------------------------
interface switch_link_if;
	logic sclk;
	logic cs_n;
	logic serial_in;
	logic serial_out;

	modport controller (
		output sclk,
		output cs_n,
		output serial_in,
		input serial_out
	);

	modport device (
		input sclk,
		input cs_n,
		input serial_in,
		output serial_out
	);
endinterface

// ### design/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;

	// two stages, first read only by second
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // sync_two_flop

// ### design/switch_device.sv
`timescale 1ns/1ps
module switch_device (
	// serial link
	switch_link_if.device link,
	// logic supply reset
	input wire logic logic_supply_reset_pin_n,
	// switch drivers
	output logic [7:0] switch_closed,
	// observation of shift stages
	output logic [7:0] shift_contents
);
	logic [switch_link_pkg::WORD_BITS-1:0] shift_q;
	logic [switch_link_pkg::WORD_BITS-1:0] latch_q;
	logic out_q;
	logic load_clk;

	// ----------------------------------------
	// shift register
	// ----------------------------------------
	// msb leaves first, new bits enter at bit 0
	always_ff @(posedge link.sclk or negedge logic_supply_reset_pin_n) begin
		if (!logic_supply_reset_pin_n) begin
			shift_q <= '0;
		end else if (!link.cs_n) begin
			shift_q <= {shift_q[6:0], link.serial_in};
		end
	end // deselected: frozen

	// ----------------------------------------
	// serial output
	// ----------------------------------------
	// last stage retimed to the falling edge
	always_ff @(negedge link.sclk or negedge logic_supply_reset_pin_n) begin
		if (!logic_supply_reset_pin_n) begin
			out_q <= 1'b0;
		end else begin
			out_q <= shift_q[switch_link_pkg::WORD_BITS-1];
		end
	end

	// frozen register keeps this at the last bit
	assign link.serial_out = out_q;

	// ----------------------------------------
	// switch latch
	// ----------------------------------------
	// rises on select rise with clock low, or on clock fall
	// while deselected, so a high clock defers the load
	assign load_clk = link.cs_n & ~link.sclk;

	// low throughout a select period, so switches hold
	always_ff @(posedge load_clk or negedge logic_supply_reset_pin_n) begin
		if (!logic_supply_reset_pin_n) begin
			latch_q <= '0;
		end else begin
			latch_q <= shift_q;
		end
	end

	// ----------------------------------------
	// drivers
	// ----------------------------------------
	// one per switch, one closes
	for (genvar n = 0; n < switch_link_pkg::WORD_BITS; n++) begin : g_switch
		assign switch_closed[n] = latch_q[n];
	end

	assign shift_contents = shift_q;
endmodule // switch_device

// ### verification/switch_link_monitor.sv
`timescale 1ns/1ps
// ----------------
// link wire checks
// ----------------
module switch_link_monitor (
	// clock and resets
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic logic_supply_reset_pin_n,
	// link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic serial_out
);
	logic sclk_q;
	logic [7:0] hist_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// bits taken at each selected sclk rise
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_q <= 1'b0;
			hist_q <= 8'h00;
		end else begin
			sclk_q <= sclk;
			if (!logic_supply_reset_pin_n)
				hist_q <= 8'h00;
			else if (sclk && !sclk_q && !cs_n)
				hist_q <= {hist_q[6:0], serial_in};
		end
	end
	property p_idle_low; cs_n |-> !sclk; endproperty
	a_idle_low: assert property (p_idle_low) else $error("sclk high while deselected");
	property p_high_time; $rose(sclk) |-> sclk [*6] ##1 !sclk; endproperty
	a_high_time: assert property (p_high_time) else $error("sclk high time wrong");
	property p_lead; $fell(cs_n) |-> !sclk [*6] ##1 sclk; endproperty
	a_lead: assert property (p_lead) else $error("select lead wrong");
	property p_in_stable; sclk |-> $stable(serial_in); endproperty
	a_in_stable: assert property (p_in_stable) else $error("data moved with sclk high");
	property p_out_on_fall;
		$changed(serial_out) && logic_supply_reset_pin_n && $past(logic_supply_reset_pin_n)
			|-> $fell(sclk);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off sclk fall");
	property p_eight_late; $fell(sclk) |-> serial_out == hist_q[7]; endproperty
	a_eight_late: assert property (p_eight_late) else $error("output not eight bits late");
	property p_lag; $rose(cs_n) |-> !$past(sclk, 1) && !$past(sclk, 6) && $past(sclk, 7); endproperty
	a_lag: assert property (p_lag) else $error("select rose with bad lag");
	property p_gap; $rose(cs_n) |-> cs_n [*6]; endproperty
	a_gap: assert property (p_gap) else $error("select gap too short");
endmodule // switch_link_monitor

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, rstn, supply_n, read, write, waitrequest;
	logic [4:0] address;
	logic [31:0] writedata, readdata, q;
	logic [7:0] sw1, sw2, sh1;
	int errors, n_checks;
	switch_link_if link();
	switch_link_if link2();
	// second device chained behind the first
	assign link2.sclk = link.sclk;
	assign link2.cs_n = link.cs_n;
	assign link2.serial_in = link.serial_out;
	switch_controller u_switch_controller (.ref_clk(ref_clk), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .link(link));
	switch_device u_switch_device (.link(link), .logic_supply_reset_pin_n(supply_n),
		.switch_closed(sw1), .shift_contents(sh1));
	switch_device u_switch_device_b (.link(link2), .logic_supply_reset_pin_n(supply_n),
		.switch_closed(sw2), .shift_contents());
	switch_link_monitor u_switch_link_monitor (.ref_clk(ref_clk), .rstn(rstn),
		.logic_supply_reset_pin_n(supply_n), .sclk(link.sclk), .cs_n(link.cs_n),
		.serial_in(link.serial_in), .serial_out(link.serial_out));
	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task close_out;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			errors++;
		end
	endtask
	// one avalon access, held until waitrequest low
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		i = 0;
		// request held; answer sampled at rising edges only
		do begin
			@(posedge ref_clk);
			i++;
		end while (waitrequest !== 1'b0 && i < 50);
		if (waitrequest !== 1'b0) begin
			errors++;
			close_out();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// one frame of n bits, then switch and return bit checks
	task frame(input logic [31:0] tx, input logic [5:0] n, input logic [7:0] sw_exp,
		input logic [31:0] rx_exp);
		logic [7:0] old;
		logic [7:0] held;
		int i;
		old = sw1;
		bus(1'b1, switch_link_pkg::TX_DATA_OFS, tx);
		bus(1'b1, switch_link_pkg::BIT_COUNT_OFS, {26'h0, n});
		bus(1'b1, switch_link_pkg::CTRL_OFS, 32'h1);
		bus(1'b0, switch_link_pkg::STATUS_OFS, 32'h0);
		chk("busy", 32'h1, q);
		chk("held switches", {24'h0, old}, {24'h0, sw1});
		for (i = 0; i < 100 && q[0] !== 1'b0; i++) begin
			// snapshot before the poll: done still clear means no load yet
			held = sw1;
			bus(1'b0, switch_link_pkg::STATUS_OFS, 32'h0);
			if (q[1] !== 1'b1)
				chk("held mid frame", {24'h0, old}, {24'h0, held});
		end
		if (i == 100) begin
			errors++;
			close_out();
		end
		chk("done set", 32'h2, q);
		chk("switches", {24'h0, sw_exp}, {24'h0, sw1});
		bus(1'b0, switch_link_pkg::RX_DATA_OFS, 32'h0);
		chk("return bits", rx_exp, q & ((32'h1 << n) - 32'h1));
		bus(1'b1, switch_link_pkg::STATUS_OFS, 32'h2);
		bus(1'b0, switch_link_pkg::STATUS_OFS, 32'h0);
		chk("done cleared", 32'h0, q);
	endtask
	// main sequence
	initial begin
		rstn = 1'b0;
		supply_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h0;
		errors = 0;
		n_checks = 0;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		supply_n <= 1'b1;
		chk("shift reset", 32'h0, {24'h0, sh1});
		chk("switch reset", 32'h0, {24'h0, sw1});
		bus(1'b0, switch_link_pkg::BIT_COUNT_OFS, 32'h0);
		chk("bit count reset", 32'h8, q);
		bus(1'b0, 5'h14, 32'h0);
		chk("unmapped read", 32'h0, q);
		$display("test reset done");
		frame(32'ha5, 6'h08, 8'ha5, 32'h00);
		frame(32'h3c, 6'h08, 8'h3c, 32'ha5);
		frame(32'habc, 6'h0c, 8'hbc, 32'h3ca);
		frame(32'h5, 6'h04, 8'hc5, 32'hb);
		frame(32'h1234, 6'h10, 8'h34, 32'hc512);
		chk("chained switches", 32'h12, {24'h0, sw2});
		$display("test frames done");
		@(posedge ref_clk);
		supply_n <= 1'b0;
		@(posedge ref_clk);
		supply_n <= 1'b1;
		@(posedge ref_clk);
		chk("supply reset switches", 32'h0, {24'h0, sw1});
		chk("supply reset shift", 32'h0, {24'h0, sh1});
		frame(32'hff, 6'h08, 8'hff, 32'h0);
		$display("test supply reset done");
		close_out();
	end
endmodule // tb_top
